/* File: src/sdio_defines.vh */
/*
 Register offsets, field positions and reset values for
 the servo drive digital I/O block. Definitions only.
*/
`ifndef SDIO_DEFINES_VH
`define SDIO_DEFINES_VH

`define SDIO_OFF_CTRL     12'h000
`define SDIO_OFF_OVR      12'h004
`define SDIO_OFF_PRESET   12'h008
`define SDIO_OFF_SETPT    12'h00c
`define SDIO_OFF_STEPS    12'h010
`define SDIO_OFF_ENCRES   12'h014
`define SDIO_OFF_STATUS   12'h018
`define SDIO_OFF_PINS     12'h01c
`define SDIO_OFF_STEPCNT  12'h020
`define SDIO_OFF_POS      12'h024
`define SDIO_OFF_CAPT     12'h028
`define SDIO_OFF_CMD      12'h02c
`define SDIO_OFF_IRQST    12'h030
`define SDIO_OFF_IRQMSK   12'h034
`define SDIO_OFF_CANCMD   12'h038

// CTRL bits
`define SDIO_CTRL_NOIO    0
`define SDIO_CTRL_FAULT   1
`define SDIO_CTRL_CANEN   2
`define SDIO_CTRL_CANRUN  3

// Override / preset bit positions (same layout)
`define SDIO_IO_STEP      0
`define SDIO_IO_DIR       1
`define SDIO_IO_CAPT      2
`define SDIO_IO_EN        3
`define SDIO_IO_BRAKE     4
`define SDIO_IO_LIMP      5
`define SDIO_IO_LIMN      6
`define SDIO_IO_W         7

// Interrupt status bits
`define SDIO_IRQ_CAPT     0
`define SDIO_IRQ_ENLOST   1
`define SDIO_IRQ_LIMP     2
`define SDIO_IRQ_LIMN     3
`define SDIO_IRQ_W        4

`define SDIO_RST_STEPS    32'h0000_0001
`define SDIO_RST_ENCRES   32'h0000_0001
`define SDIO_RST_PRESET   7'h79

`endif

/* File: src/sdio_sync.v */
/*
 Two flip-flop synchroniser bank for asynchronous discrete pins.
 Assumes one system clock and synchronous active-low reset.
*/
`timescale 1ns/1ns
module sdio_sync #(
    parameter W   = 7,
    parameter RST = 7'h7f
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= RST;
            sync_reg <= RST;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

/* File: src/sdio_top.v */
/*
 Servo drive digital I/O control: step/direction counting, encoder
 capture on an external trigger, active-low enable/brake/limit inputs,
 fault and ready outputs, per-pin override by presets, AXI4-Lite regs.
 Assumes pins are asynchronous, encoder count is on the system clock.
*/
// Summary of operation
// - Each rising edge on the step pin counts exactly one step.
// - A low direction pin inverts the sign of the speed/current command.
// - A falling edge on the capture pin snapshots the encoder count.
// - The last captured count is held and readable by software.
// - The fault output pulls low while the drive is faulted.
// - The ready output pulls low while the drive is ready.
// - Outside no-I/O mode the drive runs only while the enable pin is held low.
// - After any interruption outside no-I/O mode the enable pin must go high then low again.
// - A low brake pin applies dynamic braking.
// - A low positive limit pin blocks positive motor current.
// - A low negative limit pin blocks negative motor current.
// - Each pin may be ignored in favour of a preset value.
// - No-I/O mode ignores enable and uses fixed direction and setpoint.
// - Encoder counts per step equal encoder resolution over steps/rev.
// - Step and direction pin levels are readable as status.
// - Motion commands are also taken from a CAN-side command register.
`timescale 1ns/1ns
`include "sdio_defines.vh"
module sdio_top #(
    parameter CW = 32
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire [11:0]   s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    output wire [1:0]    s_axi_bresp,
    output wire          s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [11:0]   s_axi_araddr,
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    output wire [31:0]   s_axi_rdata,
    output wire [1:0]    s_axi_rresp,
    output wire          s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire          step_in,
    input  wire          dir_in,
    input  wire          capture_n_in,
    input  wire          enable_n_in,
    input  wire          brake_n_in,
    input  wire          limit_pos_n_in,
    input  wire          limit_neg_n_in,
    input  wire [CW-1:0] enc_count,
    input  wire          drive_fault,
    input  wire signed [31:0] cmd_in,
    output reg  signed [31:0] cmd_out,
    output reg  [CW-1:0] step_pos,
    output reg           drive_enabled,
    output reg           dyn_brake,
    output reg           inhibit_pos,
    output reg           inhibit_neg,
    output wire          fault_out,
    output wire          fault_oe_n,
    output wire          ready_out,
    output wire          ready_oe_n,
    output wire          irq
);
    // Synchronised pins, bit order follows the override layout
    wire [6:0] pin_raw;
    wire [6:0] pin_s;
    assign pin_raw = {limit_neg_n_in, limit_pos_n_in, brake_n_in,
                      enable_n_in, capture_n_in, dir_in, step_in};

    sdio_sync #(
        .W   (7),
        .RST (7'h7f)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pin_raw),
        .q       (pin_s)
    );

    reg  [3:0]    ctrl_reg;
    reg  [6:0]    ovr_reg;
    reg  [6:0]    preset_reg;
    reg  [31:0]   setpt_reg;
    reg  [31:0]   steps_reg;
    reg  [31:0]   encres_reg;
    reg  [31:0]   cancmd_reg;
    reg  [CW-1:0] capt_reg;
    reg  [4:0]    irqst_reg;
    reg  [4:0]    irqmsk_reg;
    reg  [6:0]    eff_prev_reg;
    reg           latch_reg;
    reg  [31:0]   inc_reg;
    reg           cmd_wr;

    // Effective level: preset replaces an ignored pin
    wire [6:0] eff = (pin_s & ~ovr_reg) | (preset_reg & ovr_reg);

    wire step_rise = eff[`SDIO_IO_STEP] & ~eff_prev_reg[`SDIO_IO_STEP];
    wire capt_fall = ~eff[`SDIO_IO_CAPT] & eff_prev_reg[`SDIO_IO_CAPT];
    wire noio      = ctrl_reg[`SDIO_CTRL_NOIO];
    wire en_req    = noio | ~eff[`SDIO_IO_EN];
    wire en_fall   = ~eff[`SDIO_IO_EN] & eff_prev_reg[`SDIO_IO_EN];
    wire faulted   = drive_fault | ctrl_reg[`SDIO_CTRL_FAULT];
    wire dir_lvl   = noio ? preset_reg[`SDIO_IO_DIR] : eff[`SDIO_IO_DIR];

    // Integer divide is redone every clock cycle, not per step
    function [31:0] per_step;
        input [31:0] res;
        input [31:0] steps;
        begin
            per_step = (steps == 32'h0) ? res : res / steps;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            eff_prev_reg  <= 7'h7f;
            latch_reg     <= 1'b0;
            drive_enabled <= 1'b0;
            step_pos      <= {CW{1'b0}};
            capt_reg      <= {CW{1'b0}};
            inc_reg       <= 32'h1;
        end else begin
            eff_prev_reg <= eff;
            inc_reg <= per_step(encres_reg, steps_reg);
            // Re-arm on a fresh high-to-low edge, or at once in no-I/O mode
            if (faulted || !en_req)
                latch_reg <= 1'b0;
            else if (en_fall || (noio && !latch_reg))
                latch_reg <= 1'b1;
            drive_enabled <= latch_reg & en_req & ~faulted;
            if (step_rise) begin
                if (dir_lvl)
                    step_pos <= step_pos + inc_reg[CW-1:0];
                else
                    step_pos <= step_pos - inc_reg[CW-1:0];
            end
            if (capt_fall)
                capt_reg <= enc_count;
        end
    end

    // Command path: source select, direction, limits, brake
    reg signed [31:0] src_cmd;
    reg signed [31:0] dir_cmd;
    always @* begin
        if (noio)
            src_cmd = setpt_reg;
        else if (ctrl_reg[`SDIO_CTRL_CANEN])
            src_cmd = cancmd_reg;
        else
            src_cmd = cmd_in;
        dir_cmd = dir_lvl ? src_cmd : -src_cmd;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_out     <= 32'sh0;
            dyn_brake   <= 1'b0;
            inhibit_pos <= 1'b0;
            inhibit_neg <= 1'b0;
        end else begin
            dyn_brake   <= ~eff[`SDIO_IO_BRAKE];
            inhibit_pos <= ~eff[`SDIO_IO_LIMP];
            inhibit_neg <= ~eff[`SDIO_IO_LIMN];
            if (!drive_enabled || !eff[`SDIO_IO_BRAKE])
                cmd_out <= 32'sh0;
            else if (!eff[`SDIO_IO_LIMP] && dir_cmd > 0)
                cmd_out <= 32'sh0;
            else if (!eff[`SDIO_IO_LIMN] && dir_cmd < 0)
                cmd_out <= 32'sh0;
            else
                cmd_out <= dir_cmd;
        end
    end

    // Open-collector status: enable low means the pin is pulled down
    assign fault_out  = 1'b0;
    assign fault_oe_n = ~faulted;
    assign ready_out  = 1'b0;
    assign ready_oe_n = ~(drive_enabled & ~faulted);

    // Interrupt events
    wire [4:0] ev;
    assign ev[`SDIO_IRQ_CAPT]  = capt_fall;
    assign ev[`SDIO_IRQ_ENLOST] = drive_enabled & ~latch_reg;
    assign ev[`SDIO_IRQ_LIMP]  = ~eff[`SDIO_IO_LIMP] &
                                 eff_prev_reg[`SDIO_IO_LIMP];
    assign ev[`SDIO_IRQ_LIMN]  = ~eff[`SDIO_IO_LIMN] &
                                 eff_prev_reg[`SDIO_IO_LIMN];
    // Spare event bit, kept so the status layout stays five wide
    assign ev[4] = 1'b0;
    assign irq = |(irqst_reg & irqmsk_reg);

    // AXI4-Lite slave: one write and one read in flight
    reg        aw_have_reg;
    reg        w_have_reg;
    reg [11:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0]  rresp_reg;

    assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_have_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (be[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `SDIO_OFF_CANCMD);
        end
    endfunction

    always @* begin
        cmd_wr = aw_have_reg & w_have_reg & ~bvalid_reg;
    end

    wire [31:0] wm = merge(32'h0, wdata_reg, wstrb_reg);
    wire [4:0]  w1c = (cmd_wr && awaddr_reg == `SDIO_OFF_IRQST) ?
                      wm[4:0] : 5'h0;
    wire [31:0] ctrl_wm = merge({28'h0, ctrl_reg}, wdata_reg, wstrb_reg);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 12'h0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
            ctrl_reg    <= 4'h0;
            ovr_reg     <= 7'h0;
            preset_reg  <= `SDIO_RST_PRESET;
            setpt_reg   <= 32'h0;
            steps_reg   <= `SDIO_RST_STEPS;
            encres_reg  <= `SDIO_RST_ENCRES;
            cancmd_reg  <= 32'h0;
            irqst_reg   <= 5'h0;
            irqmsk_reg  <= 5'h0;
        end else begin
            // Set wins over a simultaneous clear
            irqst_reg <= (irqst_reg & ~w1c) | ev;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
            if (cmd_wr) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= mapped(awaddr_reg) ? 2'b00 : 2'b10;
                case (awaddr_reg)
                `SDIO_OFF_CTRL:
                    ctrl_reg <= ctrl_wm[3:0];
                `SDIO_OFF_OVR:
                    ovr_reg <= wm[6:0] | (ovr_reg & ~{7{wstrb_reg[0]}});
                `SDIO_OFF_PRESET:
                    preset_reg <= wstrb_reg[0] ? wdata_reg[6:0] : preset_reg;
                `SDIO_OFF_SETPT:
                    setpt_reg <= merge(setpt_reg, wdata_reg, wstrb_reg);
                `SDIO_OFF_STEPS:
                    steps_reg <= merge(steps_reg, wdata_reg, wstrb_reg);
                `SDIO_OFF_ENCRES:
                    encres_reg <= merge(encres_reg, wdata_reg, wstrb_reg);
                `SDIO_OFF_IRQMSK:
                    irqmsk_reg <= wstrb_reg[0] ? wdata_reg[4:0] : irqmsk_reg;
                `SDIO_OFF_CANCMD:
                    cancmd_reg <= merge(cancmd_reg, wdata_reg, wstrb_reg);
                default: ;
                endcase
            end
        end
    end

    // Read side: data registered one cycle after address acceptance
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
            `SDIO_OFF_CTRL:    rdata_reg <= {28'h0, ctrl_reg};
            `SDIO_OFF_OVR:     rdata_reg <= {25'h0, ovr_reg};
            `SDIO_OFF_PRESET:  rdata_reg <= {25'h0, preset_reg};
            `SDIO_OFF_SETPT:   rdata_reg <= setpt_reg;
            `SDIO_OFF_STEPS:   rdata_reg <= steps_reg;
            `SDIO_OFF_ENCRES:  rdata_reg <= encres_reg;
            `SDIO_OFF_STATUS:
                rdata_reg <= {26'h0, inhibit_neg, inhibit_pos, dyn_brake,
                              faulted, latch_reg, drive_enabled};
            `SDIO_OFF_PINS:    rdata_reg <= {25'h0, pin_s};
            `SDIO_OFF_STEPCNT: rdata_reg <= inc_reg;
            `SDIO_OFF_POS:     rdata_reg <= step_pos;
            `SDIO_OFF_CAPT:    rdata_reg <= capt_reg;
            `SDIO_OFF_CMD:     rdata_reg <= cmd_out;
            `SDIO_OFF_IRQST:   rdata_reg <= {27'h0, irqst_reg};
            `SDIO_OFF_IRQMSK:  rdata_reg <= {27'h0, irqmsk_reg};
            `SDIO_OFF_CANCMD:  rdata_reg <= cancmd_reg;
            default:           rdata_reg <= 32'h0;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule

/* File: test/sdio_top_checker.sv */
/* Port assertions for the servo drive I/O block.
   Assumes one clock and a synchronous active-low reset; bound below. */
`timescale 1ns/1ns
module sdio_top_checker #(
    parameter CW = 32
) (
    input wire               aclk,
    input wire               aresetn,
    input wire               s_axi_bvalid,
    input wire               s_axi_bready,
    input wire [1:0]         s_axi_bresp,
    input wire               s_axi_rvalid,
    input wire               s_axi_rready,
    input wire [31:0]        s_axi_rdata,
    input wire               step_in,
    input wire               drive_fault,
    input wire signed [31:0] cmd_out,
    input wire [CW-1:0]      step_pos,
    input wire               drive_enabled,
    input wire               dyn_brake,
    input wire               inhibit_pos,
    input wire               inhibit_neg,
    input wire               fault_oe_n,
    input wire               ready_oe_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    fault_pull_a: assert property (drive_fault |-> !fault_oe_n)
        else $error("fault pin not pulled low");
    ready_fault_a: assert property (!fault_oe_n &&
        !$past(fault_oe_n) && !$past(fault_oe_n, 2) |-> ready_oe_n)
        else $error("ready shown while faulted");
    brake_zero_a: assert property (dyn_brake && $past(dyn_brake)
        |-> cmd_out == 0) else $error("command while braking");
    pos_block_a: assert property (inhibit_pos && $past(inhibit_pos)
        |-> !(cmd_out > 0)) else $error("positive command at limit");
    neg_block_a: assert property (inhibit_neg && $past(inhibit_neg)
        |-> !(cmd_out < 0)) else $error("negative command at limit");
    off_zero_a: assert property (!drive_enabled &&
        !$past(drive_enabled) |-> cmd_out == 0)
        else $error("command while disabled");
    step_cause_a: assert property ($changed(step_pos) |->
        ($past(step_in, 2) && !$past(step_in, 3)) ||
        ($past(step_in, 3) && !$past(step_in, 4)))
        else $error("position moved without a step edge");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind sdio_top sdio_top_checker #(.CW(CW)) i_sdio_top_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .step_in(step_in),
    .drive_fault(drive_fault), .cmd_out(cmd_out), .step_pos(step_pos),
    .drive_enabled(drive_enabled), .dyn_brake(dyn_brake),
    .inhibit_pos(inhibit_pos), .inhibit_neg(inhibit_neg),
    .fault_oe_n(fault_oe_n), .ready_oe_n(ready_oe_n)
);

/* File: test/sdio_ctrl_model.sv */
/* Motion controller and operator switches on the pin side.
   Assumes the bench calls its tasks just after a rising edge. */
`timescale 1ns/1ns
module sdio_ctrl_model (
    input  wire aclk,
    output reg  step_in,
    output reg  dir_in,
    output reg  capture_n_in,
    output reg  enable_n_in,
    output reg  brake_n_in,
    output reg  limit_pos_n_in,
    output reg  limit_neg_n_in
);
    initial {limit_neg_n_in, limit_pos_n_in, brake_n_in, enable_n_in,
        capture_n_in, dir_in, step_in} = 7'h7e;
    // Levels held six cycles so sync and edge detect have settled
    task pins(input [6:0] v);
        begin
            @(posedge aclk);
            {limit_neg_n_in, limit_pos_n_in, brake_n_in, enable_n_in,
                capture_n_in, dir_in, step_in} <= v;
            repeat (6) @(posedge aclk);
        end
    endtask
    task steps(input integer n);
        begin
            repeat (n) begin
                step_in <= 1'b1;
                repeat (3) @(posedge aclk);
                step_in <= 1'b0;
                repeat (3) @(posedge aclk);
            end
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule

/* File: test/servo_drive_digital_io_control_bench.sv */
/* Self-checking bench for the servo drive I/O block.
   Assumes the pin-side model and the bound checker are compiled too. */
`timescale 1ns/1ns
`include "sdio_defines.vh"
`define CHK(g, e) begin checks_done = checks_done + 1; \
    if ((g) !== (e)) begin bad_count = bad_count + 1; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module servo_drive_digital_io_control_bench;
    reg               aclk = 1'b0;
    reg               aresetn = 1'b0;
    reg  [11:0]       s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    reg               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    reg               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg               s_axi_bready = 1'b0, drive_fault = 1'b0;
    reg  [31:0]       s_axi_wdata = 32'h0, enc_count = 32'h0, rq;
    reg signed [31:0] cmd_in = 32'sh0;
    reg  [1:0]        rr;
    reg  [3:0]        s_axi_wstrb = 4'hf;
    reg  [78:0]       rows [0:4];
    reg  [11:0]       ra;
    reg               rw;
    reg  [31:0]       rwd, req;
    reg  [1:0]        rer;
    integer           bad_count = 0, checks_done = 0, cyc = 0, i;
    wire              s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire              s_axi_arready, s_axi_rvalid, irq;
    wire [1:0]        s_axi_bresp, s_axi_rresp;
    wire [31:0]       s_axi_rdata, step_pos;
    wire signed [31:0] cmd_out;
    wire              step_in, dir_in, capture_n_in, enable_n_in;
    wire              brake_n_in, limit_pos_n_in, limit_neg_n_in;
    wire              drive_enabled, dyn_brake, inhibit_pos, inhibit_neg;
    wire              fault_out, fault_oe_n, ready_out, ready_oe_n;

    always #20 aclk = ~aclk;

    sdio_top #(.CW(32)) i_sdio_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .step_in(step_in), .dir_in(dir_in),
        .capture_n_in(capture_n_in), .enable_n_in(enable_n_in),
        .brake_n_in(brake_n_in), .limit_pos_n_in(limit_pos_n_in),
        .limit_neg_n_in(limit_neg_n_in), .enc_count(enc_count),
        .drive_fault(drive_fault), .cmd_in(cmd_in), .cmd_out(cmd_out),
        .step_pos(step_pos), .drive_enabled(drive_enabled),
        .dyn_brake(dyn_brake), .inhibit_pos(inhibit_pos),
        .inhibit_neg(inhibit_neg), .fault_out(fault_out),
        .fault_oe_n(fault_oe_n), .ready_out(ready_out),
        .ready_oe_n(ready_oe_n), .irq(irq));

    sdio_ctrl_model i_sdio_ctrl_model (.aclk(aclk), .step_in(step_in),
        .dir_in(dir_in), .capture_n_in(capture_n_in),
        .enable_n_in(enable_n_in), .brake_n_in(brake_n_in),
        .limit_pos_n_in(limit_pos_n_in), .limit_neg_n_in(limit_neg_n_in));

    task wrap_up;
        begin
            $display("checks %0d, mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            bad_count = bad_count + 1;
            wrap_up;
        end
    end

    // Ready sampled mid-cycle, so it is the value seen at the next edge
    task xfer(input w, input [11:0] a, input [31:0] d);
        reg ta, tw, td;
        integer t;
        begin
            ta = 1'b0;
            tw = !w;
            td = 1'b0;
            t = 0;
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_arvalid <= !w;
            s_axi_bready <= w;
            s_axi_rready <= !w;
            while (!td && t < 200) begin
                @(negedge aclk);
                t = t + 1;
                if (!ta) ta = w ? s_axi_awready : s_axi_arready;
                if (!tw) tw = s_axi_wready;
                td = w ? s_axi_bvalid : s_axi_rvalid;
                rq = s_axi_rdata;
                rr = w ? s_axi_bresp : s_axi_rresp;
                @(posedge aclk);
                s_axi_awvalid <= w && !ta;
                s_axi_wvalid <= w && !tw;
                s_axi_arvalid <= !w && !ta;
                s_axi_bready <= w && !td;
                s_axi_rready <= !w && !td;
            end
            if (!td) begin
                bad_count = bad_count + 1;
                wrap_up;
            end
            // Let an edge pass so the next call never re-raises a strobe
            @(posedge aclk);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input [11:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    initial begin
        rows[0] = {`SDIO_OFF_ENCRES, 1'b1, 32'h3e8, 32'h3e8, 2'b00};
        rows[1] = {`SDIO_OFF_STEPS, 1'b1, 32'hfa, 32'hfa, 2'b00};
        rows[2] = {`SDIO_OFF_STEPCNT, 1'b0, 32'h0, 32'h4, 2'b00};
        rows[3] = {`SDIO_OFF_SETPT, 1'b1, 32'h37, 32'h37, 2'b00};
        rows[4] = {12'h0fc, 1'b1, 32'h1, 32'h0, 2'b10};
        repeat (12) @(posedge aclk);
        `CHK({cmd_out, drive_enabled, ready_oe_n, irq}, {32'h0, 3'b010})
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`SDIO_OFF_STEPS);
        `CHK(rq, `SDIO_RST_STEPS)
        rd(`SDIO_OFF_PRESET);
        `CHK(rq, {25'h0, `SDIO_RST_PRESET})
        $display("reset test done");
        for (i = 0; i < 5; i = i + 1) begin
            {ra, rw, rwd, req, rer} = rows[i];
            if (rw) wr(ra, rwd);
            if (rw) `CHK(rr, rer)
            rd(ra);
            `CHK({rq, rr}, {req, rer})
        end
        $display("register table done");
        cmd_in <= 32'sh64;
        i_sdio_ctrl_model.pins(7'h76);
        `CHK({drive_enabled, ready_oe_n}, 2'b10)
        `CHK(cmd_out, 32'sh64)
        i_sdio_ctrl_model.steps(3);
        `CHK(step_pos, 32'hc)
        rd(`SDIO_OFF_PINS);
        `CHK(rq[1:0], 2'b10)
        i_sdio_ctrl_model.pins(7'h74);
        `CHK(cmd_out, -32'sh64)
        i_sdio_ctrl_model.steps(1);
        `CHK(step_pos, 32'h8)
        i_sdio_ctrl_model.pins(7'h34);
        `CHK({inhibit_neg, cmd_out}, {1'b1, 32'h0})
        i_sdio_ctrl_model.pins(7'h56);
        `CHK({inhibit_pos, cmd_out}, {1'b1, 32'h0})
        i_sdio_ctrl_model.pins(7'h76);
        `CHK(cmd_out, 32'sh64)
        $display("step and limit test done");
        drive_fault <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK({fault_oe_n, ready_oe_n, drive_enabled}, 3'b010)
        `CHK({fault_out, ready_out}, 2'b00)
        drive_fault <= 1'b0;
        repeat (6) @(posedge aclk);
        `CHK({fault_oe_n, drive_enabled}, 2'b10)
        i_sdio_ctrl_model.pins(7'h7e);
        i_sdio_ctrl_model.pins(7'h76);
        `CHK(drive_enabled, 1'b1)
        $display("fault test done");
        wr(`SDIO_OFF_IRQMSK, 32'h1);
        enc_count <= 32'h1234;
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        i_sdio_ctrl_model.pins(7'h72);
        `CHK(irq, 1'b1)
        enc_count <= 32'h9999;
        i_sdio_ctrl_model.pins(7'h76);
        rd(`SDIO_OFF_CAPT);
        `CHK(rq, 32'h1234)
        wr(`SDIO_OFF_IRQST, 32'h1);
        wr(`SDIO_OFF_IRQMSK, 32'h0);
        i_sdio_ctrl_model.pins(7'h72);
        `CHK(irq, 1'b0)
        rd(`SDIO_OFF_CAPT);
        `CHK(rq, 32'h9999)
        rd(`SDIO_OFF_IRQST);
        `CHK(rq[0], 1'b1)
        $display("capture test done");
        wr(`SDIO_OFF_CANCMD, 32'h4d);
        wr(`SDIO_OFF_CTRL, 32'h4);
        repeat (4) @(posedge aclk);
        `CHK(cmd_out, 32'sh4d)
        wr(`SDIO_OFF_CTRL, 32'h0);
        i_sdio_ctrl_model.pins(7'h7e);
        `CHK({drive_enabled, cmd_out}, 33'h0)
        wr(`SDIO_OFF_PRESET, 32'h7b);
        wr(`SDIO_OFF_CTRL, 32'h1);
        repeat (4) @(posedge aclk);
        `CHK({drive_enabled, cmd_out}, {1'b1, 32'h37})
        wr(`SDIO_OFF_PRESET, 32'h79);
        repeat (4) @(posedge aclk);
        `CHK(cmd_out, -32'sh37)
        i_sdio_ctrl_model.pins(7'h6e);
        `CHK({dyn_brake, cmd_out}, {1'b1, 32'h0})
        wr(`SDIO_OFF_OVR, 32'h10);
        repeat (4) @(posedge aclk);
        `CHK(dyn_brake, 1'b0)
        $display("mode and brake test done");
        // Only byte lane 0 may land
        s_axi_wstrb <= 4'h1;
        wr(`SDIO_OFF_SETPT, 32'hffff_ff12);
        s_axi_wstrb <= 4'hf;
        rd(`SDIO_OFF_SETPT);
        `CHK(rq, 32'h12)
        wr(`SDIO_OFF_CTRL, 32'h2);
        `CHK({fault_oe_n, ready_oe_n}, 2'b01)
        $display("strobe and soft fault test done");
        wrap_up;
    end
endmodule
